// *** hw/rxar_pkg.sv ***
// Shared constants and types for the receive alarm reporting block.
package rxar_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_STATUS_BURST = 8'h02;
   localparam logic [7:0] OFS_MASK = 8'h03;
   localparam logic [7:0] OFS_VIOL_COUNT = 8'h04;
   localparam logic [7:0] OFS_ERR_COUNT = 8'h05;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_CMD_RESYNC = 0;
   localparam int CTRL_NO_AUTO_RESYNC = 1;
   localparam int CTRL_SF_ALL_FBITS = 3;
   localparam int CTRL_EXT_MODE = 4;

   // ----------------------------------------------------------------
   // Status and mask fields
   // ----------------------------------------------------------------
   localparam int ST_VIOL_SAT = 7;
   localparam int ST_ERR_SAT = 6;
   localparam int ST_REMOTE = 5;
   localparam int ST_CARRIER = 4;
   localparam int ST_FRAME_ERR = 3;
   localparam int ST_ZERO_SUB = 2;
   localparam int ST_ALL_ONES = 1;
   localparam int ST_SYNC_LOSS = 0;
   localparam int ST_DIRECT_W = 6;

   // ----------------------------------------------------------------
   // Error count register fields
   // ----------------------------------------------------------------
   localparam int ECR_FL_LSB = 4;
   localparam int ECR_SF_LSB = 0;
   localparam int ECR_FIELD_W = 4;

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_VIOL_COUNT = 8'h00;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic RST_SYNC_LOSS = 1'b1;
   localparam logic [7:0] VIOL_FULL = 8'hff;
   localparam logic [7:0] VIOL_LAST = 8'hfe;
   localparam logic [3:0] NIBBLE_FULL = 4'hf;
   localparam logic [3:0] NIBBLE_LAST = 4'he;
   localparam int OOF_WINDOW = 4;
   localparam logic [2:0] OOF_LIMIT = 3'h2;

   // ----------------------------------------------------------------
   // Line-side inputs, all timed by the line clock
   // ----------------------------------------------------------------
   typedef struct packed {
      logic bipolar_viol;
      logic rx_carrier_loss;
      logic rx_remote_alarm;
      logic zero_sub_detect;
      logic rx_all_ones_alarm;
      logic fbit_valid;
      logic fbit_err;
      logic fbit_is_fs;
      logic crc_err;
      logic sig_bit;
      logic chan_lsb;
      logic sync_found;
   } rxar_line_type;

endpackage

// *** hw/rxar_sync.sv ***
// Three-stage input synchroniser with agreement filter, one lane per bit.
`timescale 1ns/1ps
module rxar_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Asynchronous inputs and filtered outputs
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_lane
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic flt_r;
         logic flt_nxt;
         always_comb begin
            flt_nxt = flt_r;
            if (s2_r == s3_r) begin
               flt_nxt = s3_r;
            end
         end
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               flt_r <= 1'b0;
            end else begin
               s1_r <= async_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               flt_r <= flt_nxt;
            end
         end
         assign sync_out[i] = flt_r;
      end
   endgenerate

endmodule

// *** hw/rxar_top.sv ***
// Receive alarm reporting: interrupt mask, alarm status, error counters, sync loss.
//
// How it works
// - Signaling bit shown every channel time
// - Alarms on pins plus registered interrupt
// - Direct and count-overflow interrupt sources
// - Mask bit one enables, zero masks
// - Clearing mask bit clears pending interrupt
// - Status read clears direct unless present
// - Overflow clears by non-full preset or by clearing its mask bit
// - Burst status read clears nothing
// - Presettable counters; saturated event sets status
// - Out-of-frame: two of four bits wrong
// - Out-of-frame increments frame-loss counter
// - Extended: out-of-frame or CRC counts superframe
// - Twelve-frame: control bit selects counted bits
// - Sync-loss high during resync, status latched
// - Auto-resync: sync-loss follows carrier/out-of-frame
// - Violation counter saturates at 255, interrupts
// - Host presets violation counter, always readable
// - Violation counter counts even during resync
// - Four-bit counters saturate at 15
// - Both four-bit counters share one register
// - Four-bit counters frozen during resync
// - Violation saturation sets status bit
// - Auto-resync: sync-loss rises on carrier loss or out-of-frame
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module rxar_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Line side
   input wire logic rx_line_clk,
   input wire rxar_pkg::rxar_line_type line_in,
   // Alarm and signaling outputs
   output logic rx_sync_loss,
   output logic rx_signaling_bits,
   output logic irq
);

   localparam int LINE_W = $bits(rxar_pkg::rxar_line_type);

   // ----------------------------------------------------------------
   // Input synchronisation and line clock edge
   // ----------------------------------------------------------------
   logic [LINE_W:0] sync_q;
   rxar_pkg::rxar_line_type ln;
   logic clk_prev_r;
   logic clk_prev_nxt;
   logic tick;

   rxar_sync #(
      .WIDTH(LINE_W + 1)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in({rx_line_clk, line_in}),
      .sync_out(sync_q)
   );

   assign ln = rxar_pkg::rxar_line_type'(sync_q[LINE_W-1:0]);
   assign clk_prev_nxt = sync_q[LINE_W];
   assign tick = sync_q[LINE_W] & ~clk_prev_r;

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic wr_mask;
   logic wr_viol;
   logic wr_err;
   logic rd_status;
   logic rd_burst;

   assign wr_ctrl = reg_wr & (reg_addr == rxar_pkg::OFS_CTRL);
   assign wr_mask = reg_wr & (reg_addr == rxar_pkg::OFS_MASK);
   assign wr_viol = reg_wr & (reg_addr == rxar_pkg::OFS_VIOL_COUNT);
   assign wr_err = reg_wr & (reg_addr == rxar_pkg::OFS_ERR_COUNT);
   assign rd_status = reg_rd & (reg_addr == rxar_pkg::OFS_STATUS);
   assign rd_burst = reg_rd & (reg_addr == rxar_pkg::OFS_STATUS_BURST);

   // ----------------------------------------------------------------
   // State declarations
   // ----------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] viol_r;
   logic [7:0] viol_nxt;
   logic [3:0] fl_r;
   logic [3:0] fl_nxt;
   logic [3:0] sf_r;
   logic [3:0] sf_nxt;
   logic [rxar_pkg::OOF_WINDOW-1:0] hist_r;
   logic [rxar_pkg::OOF_WINDOW-1:0] hist_nxt;
   logic sync_loss_r;
   logic sync_loss_nxt;
   logic sig_r;
   logic sig_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // ----------------------------------------------------------------
   // Framing bit test and out-of-frame detection
   // ----------------------------------------------------------------
   function automatic logic [2:0] count_ones(input logic [rxar_pkg::OOF_WINDOW-1:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int k = 0; k < rxar_pkg::OOF_WINDOW; k++) begin
         n = n + {2'b00, v[k]};
      end
      return n;
   endfunction

   logic ext_mode;
   logic tested;
   logic [rxar_pkg::OOF_WINDOW-1:0] hist_shift;
   logic oof_evt;
   logic framing_bit_error_evt;

   assign ext_mode = ctrl_r[rxar_pkg::CTRL_EXT_MODE];
   assign tested = tick & ln.fbit_valid & (ext_mode | ~ln.fbit_is_fs);
   assign hist_shift = {hist_r[rxar_pkg::OOF_WINDOW-2:0], ln.fbit_err};
   assign oof_evt = tested & ~sync_loss_r & (count_ones(hist_shift) >= rxar_pkg::OOF_LIMIT);
   assign framing_bit_error_evt = tested & ln.fbit_err;

   always_comb begin
      hist_nxt = hist_r;
      sig_nxt = sig_r;
      if (sync_loss_r || oof_evt) begin
         hist_nxt = '0;
      end else if (tested) begin
         hist_nxt = hist_shift;
      end
      if (tick && ln.chan_lsb) begin
         sig_nxt = ln.sig_bit;
      end
   end

   // ----------------------------------------------------------------
   // Sync loss indication
   // ----------------------------------------------------------------
   logic cmd_resync;
   assign cmd_resync = wr_ctrl & reg_wdata[rxar_pkg::CTRL_CMD_RESYNC]
      & ~ctrl_r[rxar_pkg::CTRL_CMD_RESYNC];

   always_comb begin
      sync_loss_nxt = sync_loss_r;
      if (tick && ln.sync_found) begin
         sync_loss_nxt = 1'b0;
      end
      if (!ctrl_r[rxar_pkg::CTRL_NO_AUTO_RESYNC] && (oof_evt || ln.rx_carrier_loss)) begin
         sync_loss_nxt = 1'b1;
      end
      if (cmd_resync) begin
         sync_loss_nxt = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Error counters
   // ----------------------------------------------------------------
   logic viol_evt;
   logic fl_evt;
   logic sf_evt;
   logic sf_fbit;

   assign viol_evt = tick & ln.bipolar_viol;
   assign fl_evt = oof_evt & ~sync_loss_r;
   assign sf_fbit = tick & ln.fbit_valid & ln.fbit_err
      & (~ln.fbit_is_fs | ctrl_r[rxar_pkg::CTRL_SF_ALL_FBITS]);
   assign sf_evt = ~sync_loss_r
      & (ext_mode ? (oof_evt | (tick & ln.crc_err)) : sf_fbit);

   always_comb begin
      viol_nxt = viol_r;
      fl_nxt = fl_r;
      sf_nxt = sf_r;
      if (wr_viol) begin
         viol_nxt = reg_wdata;
      end else if (viol_evt && viol_r != rxar_pkg::VIOL_FULL) begin
         viol_nxt = viol_r + 8'h01;
      end
      if (wr_err) begin
         fl_nxt = reg_wdata[rxar_pkg::ECR_FL_LSB +: rxar_pkg::ECR_FIELD_W];
         sf_nxt = reg_wdata[rxar_pkg::ECR_SF_LSB +: rxar_pkg::ECR_FIELD_W];
      end else begin
         if (fl_evt && fl_r != rxar_pkg::NIBBLE_FULL) begin
            fl_nxt = fl_r + 4'h1;
         end
         if (sf_evt && sf_r != rxar_pkg::NIBBLE_FULL) begin
            sf_nxt = sf_r + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control, mask, status and interrupt
   // ----------------------------------------------------------------
   logic [rxar_pkg::ST_DIRECT_W-1:0] cond;
   logic viol_sat_set;
   logic err_sat_set;
   logic viol_sat_clr;
   logic err_sat_clr;

   assign cond = {ln.rx_remote_alarm, ln.rx_carrier_loss, framing_bit_error_evt,
                  ln.zero_sub_detect, ln.rx_all_ones_alarm, sync_loss_r};
   assign viol_sat_set = viol_evt & ~wr_viol
      & ((viol_r == rxar_pkg::VIOL_FULL) | (viol_r == rxar_pkg::VIOL_LAST));
   assign err_sat_set = ~wr_err
      & ((fl_evt & ((fl_r == rxar_pkg::NIBBLE_FULL) | (fl_r == rxar_pkg::NIBBLE_LAST)))
      | (sf_evt & ((sf_r == rxar_pkg::NIBBLE_FULL) | (sf_r == rxar_pkg::NIBBLE_LAST))));
   assign viol_sat_clr = wr_viol & (reg_wdata != rxar_pkg::VIOL_FULL);
   assign err_sat_clr = wr_err
      & (reg_wdata[rxar_pkg::ECR_FL_LSB +: rxar_pkg::ECR_FIELD_W] != rxar_pkg::NIBBLE_FULL)
      & (reg_wdata[rxar_pkg::ECR_SF_LSB +: rxar_pkg::ECR_FIELD_W] != rxar_pkg::NIBBLE_FULL);

   always_comb begin
      ctrl_nxt = wr_ctrl ? reg_wdata : ctrl_r;
      mask_nxt = wr_mask ? reg_wdata : mask_r;
      status_nxt = status_r;
      if (rd_status) begin
         status_nxt[rxar_pkg::ST_DIRECT_W-1:0] = '0;
      end
      status_nxt[rxar_pkg::ST_DIRECT_W-1:0] = status_nxt[rxar_pkg::ST_DIRECT_W-1:0] | cond;
      if (viol_sat_clr) begin
         status_nxt[rxar_pkg::ST_VIOL_SAT] = 1'b0;
      end
      if (err_sat_clr) begin
         status_nxt[rxar_pkg::ST_ERR_SAT] = 1'b0;
      end
      if (viol_sat_set) begin
         status_nxt[rxar_pkg::ST_VIOL_SAT] = 1'b1;
      end
      if (err_sat_set) begin
         status_nxt[rxar_pkg::ST_ERR_SAT] = 1'b1;
      end
      if (wr_mask) begin
         status_nxt = status_nxt & reg_wdata;
      end
      irq_nxt = |(status_nxt & mask_nxt);
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            rxar_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
            rxar_pkg::OFS_STATUS: rdata_nxt = status_r;
            rxar_pkg::OFS_STATUS_BURST: rdata_nxt = status_r;
            rxar_pkg::OFS_MASK: rdata_nxt = mask_r;
            rxar_pkg::OFS_VIOL_COUNT: rdata_nxt = viol_r;
            rxar_pkg::OFS_ERR_COUNT: rdata_nxt = {fl_r, sf_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         clk_prev_r <= 1'b0;
         ctrl_r <= rxar_pkg::RST_CTRL;
         mask_r <= rxar_pkg::RST_MASK;
         status_r <= rxar_pkg::RST_STATUS;
         viol_r <= rxar_pkg::RST_VIOL_COUNT;
         fl_r <= rxar_pkg::RST_NIBBLE;
         sf_r <= rxar_pkg::RST_NIBBLE;
         hist_r <= '0;
         sync_loss_r <= rxar_pkg::RST_SYNC_LOSS;
         sig_r <= 1'b0;
         irq_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         clk_prev_r <= clk_prev_nxt;
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         viol_r <= viol_nxt;
         fl_r <= fl_nxt;
         sf_r <= sf_nxt;
         hist_r <= hist_nxt;
         sync_loss_r <= sync_loss_nxt;
         sig_r <= sig_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign rx_sync_loss = sync_loss_r;
   assign rx_signaling_bits = sig_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   AST_SIG_BIT: assert property (tick && ln.chan_lsb |=> rx_signaling_bits == $past(ln.sig_bit))
      else $error("signaling output did not take the channel bit");
   AST_IRQ_LEVEL: assert property (irq == |(status_r & mask_r))
      else $error("interrupt output disagrees with enabled pending bits");
   AST_MASK_CLEAR: assert property (wr_mask |=> (status_r & ~$past(reg_wdata)) == 8'h00)
      else $error("masked source still pending after mask write");
   AST_READ_CLEAR: assert property (rd_status && !ln.rx_remote_alarm |=> !status_r[rxar_pkg::ST_REMOTE])
      else $error("remote alarm status not cleared by status read");
   AST_OVF_KEEP: assert property (rd_status && status_r[rxar_pkg::ST_VIOL_SAT] && !wr_viol && !wr_mask
      |=> status_r[rxar_pkg::ST_VIOL_SAT])
      else $error("overflow status cleared by status read");
   AST_BURST_KEEP: assert property (rd_burst |=> (status_r & $past(status_r)) == $past(status_r))
      else $error("burst status read cleared a bit");
   AST_VIOL_INC: assert property (viol_evt && !wr_viol && viol_r != rxar_pkg::VIOL_FULL
      |=> viol_r == $past(viol_r) + 8'h01)
      else $error("violation counter did not advance by one");
   AST_VIOL_SAT: assert property (viol_evt && !wr_viol && viol_r == rxar_pkg::VIOL_FULL
      |=> viol_r == rxar_pkg::VIOL_FULL && status_r[rxar_pkg::ST_VIOL_SAT])
      else $error("saturated violation counter did not flag overflow");
   AST_ECR_FREEZE: assert property (sync_loss_r && !wr_err |=> $stable(fl_r) && $stable(sf_r))
      else $error("four-bit counters moved during resync");
   AST_OOF_COUNT: assert property (fl_evt && !wr_err && fl_r != rxar_pkg::NIBBLE_FULL
      |=> fl_r == $past(fl_r) + 4'h1)
      else $error("frame-loss counter missed an out-of-frame event");
   AST_AUTO_RESYNC: assert property (oof_evt && !ctrl_r[rxar_pkg::CTRL_NO_AUTO_RESYNC]
      |=> rx_sync_loss ##1 status_r[rxar_pkg::ST_SYNC_LOSS] || $past(wr_mask))
      else $error("sync loss not raised and latched after out-of-frame");
   AST_PRESET_CLR: assert property (wr_viol && reg_wdata != rxar_pkg::VIOL_FULL && !viol_evt
      |=> !status_r[rxar_pkg::ST_VIOL_SAT])
      else $error("non-full preset did not clear violation overflow");

   COV_VIOL_OVF: cover property (viol_sat_set && mask_r[rxar_pkg::ST_VIOL_SAT] ##1 irq);
   COV_OOF: cover property (oof_evt ##1 rx_sync_loss);
   COV_RESYNC_DONE: cover property (rx_sync_loss ##1 !rx_sync_loss);
   COV_BURST: cover property (rd_burst && irq);

endmodule

// *** dv/rxar_line_model.sv ***
// Line-side partner model: makes the receive line clock and the line bits.
`timescale 1ns/1ps
module rxar_line_model (
   // Line clock and line bits
   output logic rx_line_clk,
   output rxar_pkg::rxar_line_type line_in
);
   initial begin
      rx_line_clk = 1'b0;
      line_in = '0;
   end

   // ----------------------------------------------------------------
   // One 80 ns bit time
   // ----------------------------------------------------------------
   // Data is set while the clock is low and held across the rising edge.
   task automatic send_bit(input logic [11:0] bits);
      line_in = rxar_pkg::rxar_line_type'(bits);
      #40;
      rx_line_clk = 1'b1;
      #40;
      rx_line_clk = 1'b0;
      // Alarm inputs are levels, so they hold until the next bit is sent.
   endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench for the receive alarm reporting block.
`timescale 1ns/1ps
module tb_top;
   typedef struct {
      logic [11:0] line;
      logic [7:0] status;
   } rxar_row_type;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rx_line_clk;
   rxar_pkg::rxar_line_type line_in;
   logic rx_sync_loss;
   logic rx_signaling_bits;
   logic irq;
   int n_fail = 0;
   int num_checks = 0;
   logic [7:0] rd_val;
   rxar_row_type rows [5] = '{'{12'h200, 8'h20}, '{12'h400, 8'h10}, '{12'h100, 8'h04},
      '{12'h080, 8'h02}, '{12'h060, 8'h08}};

   always #5 ref_clk = ~ref_clk;

   rxar_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_line_clk(rx_line_clk),
      .line_in(line_in), .rx_sync_loss(rx_sync_loss), .rx_signaling_bits(rx_signaling_bits),
      .irq(irq));
   rxar_line_model line_far (.rx_line_clk(rx_line_clk), .line_in(line_in));

   // ----------------------------------------------------------------
   // Bus, line and comparison tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, seen);
         n_fail++;
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_read(a, d);
      check($sformatf("reg %h", a), d, exp);
   endtask
   task automatic chk_sync(input logic exp);
      repeat (2) @(posedge ref_clk);
      #1;
      check("rx_sync_loss", {7'h00, rx_sync_loss}, {7'h00, exp});
   endtask
   task automatic chk_irq(input logic exp);
      repeat (2) @(posedge ref_clk);
      #1;
      check("irq", {7'h00, irq}, {7'h00, exp});
   endtask
   task automatic send(input logic [11:0] bits);
      line_far.send_bit(bits);
      repeat (8) @(posedge ref_clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk_sync(1'b1);
      chk_irq(1'b0);
      check_reg(rxar_pkg::OFS_MASK, rxar_pkg::RST_MASK);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, rxar_pkg::RST_VIOL_COUNT);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h00);
      reg_write(rxar_pkg::OFS_MASK, 8'ha5);
      reg_write(rxar_pkg::OFS_VIOL_COUNT, 8'h3c);
      reg_write(rxar_pkg::OFS_ERR_COUNT, 8'h96);
      reg_write(8'h07, 8'hff);
      check_reg(rxar_pkg::OFS_MASK, 8'ha5);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, 8'h3c);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h96);
      check_reg(8'h07, 8'h00);
      reg_write(rxar_pkg::OFS_MASK, 8'h00);
      // Sync loss is present after reset: no read may clear its status bit.
      check_reg(rxar_pkg::OFS_STATUS_BURST, 8'h01);
      check_reg(rxar_pkg::OFS_STATUS, 8'h01);
      send(12'h001);
      chk_sync(1'b0);
      check_reg(rxar_pkg::OFS_STATUS_BURST, 8'h01);
      check_reg(rxar_pkg::OFS_STATUS, 8'h01);
      check_reg(rxar_pkg::OFS_STATUS, 8'h00);
      // Direct alarms with auto resync off.
      reg_write(rxar_pkg::OFS_CTRL, 8'h02);
      foreach (rows[i]) begin
         send(rows[i].line);
         send(12'h000);
         chk_sync(1'b0);
         check_reg(rxar_pkg::OFS_STATUS, rows[i].status);
         check_reg(rxar_pkg::OFS_STATUS, 8'h00);
      end
      // An alarm still present survives a clearing read.
      send(12'h200);
      reg_write(rxar_pkg::OFS_MASK, 8'h20);
      chk_irq(1'b1);
      check_reg(rxar_pkg::OFS_STATUS, 8'h20);
      chk_irq(1'b1);
      send(12'h000);
      check_reg(rxar_pkg::OFS_STATUS, 8'h20);
      chk_irq(1'b0);
      reg_write(rxar_pkg::OFS_MASK, 8'h00);
      // Commanded resync: violation counter runs, error counters stand still.
      reg_write(rxar_pkg::OFS_VIOL_COUNT, 8'h00);
      reg_write(rxar_pkg::OFS_ERR_COUNT, 8'h00);
      reg_write(rxar_pkg::OFS_CTRL, 8'h01);
      chk_sync(1'b1);
      send(12'h868);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, 8'h01);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h00);
      reg_write(rxar_pkg::OFS_CTRL, 8'h10);
      send(12'h001);
      chk_sync(1'b0);
      // Extended mode: errors four apart are no loss of frame, two in four are.
      send(12'h060);
      send(12'h040);
      send(12'h040);
      send(12'h040);
      send(12'h060);
      chk_sync(1'b0);
      send(12'h060);
      chk_sync(1'b1);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h11);
      send(12'h001);
      chk_sync(1'b0);
      send(12'h008);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h12);
      // Twelve-frame mode: signaling framing bits count only with ctrl bit 3.
      reg_write(rxar_pkg::OFS_CTRL, 8'h00);
      send(12'h070);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h12);
      reg_write(rxar_pkg::OFS_CTRL, 8'h08);
      send(12'h070);
      chk_sync(1'b0);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h13);
      // Violation counter saturation, preset and masking.
      reg_write(rxar_pkg::OFS_MASK, 8'h80);
      reg_write(rxar_pkg::OFS_VIOL_COUNT, 8'hfe);
      send(12'h800);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, 8'hff);
      chk_irq(1'b1);
      reg_read(rxar_pkg::OFS_STATUS, rd_val);
      check("status_viol_sat", rd_val & 8'h80, 8'h80);
      chk_irq(1'b1);
      send(12'h800);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, 8'hff);
      reg_write(rxar_pkg::OFS_VIOL_COUNT, 8'h10);
      chk_irq(1'b0);
      reg_write(rxar_pkg::OFS_VIOL_COUNT, 8'hff);
      send(12'h800);
      chk_irq(1'b1);
      reg_write(rxar_pkg::OFS_MASK, 8'h00);
      chk_irq(1'b0);
      reg_write(rxar_pkg::OFS_MASK, 8'h80);
      chk_irq(1'b0);
      // Error counter saturation in extended mode.
      reg_write(rxar_pkg::OFS_CTRL, 8'h10);
      reg_write(rxar_pkg::OFS_MASK, 8'h40);
      reg_write(rxar_pkg::OFS_ERR_COUNT, 8'h0f);
      send(12'h008);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h0f);
      chk_irq(1'b1);
      reg_read(rxar_pkg::OFS_STATUS, rd_val);
      check("status_err_sat", rd_val & 8'h40, 8'h40);
      chk_irq(1'b1);
      reg_write(rxar_pkg::OFS_ERR_COUNT, 8'h0e);
      chk_irq(1'b0);
      // Carrier loss with auto resync on raises sync loss.
      send(12'h400);
      chk_sync(1'b1);
      send(12'h001);
      chk_sync(1'b0);
      // Signaling bit follows the channel LSB only.
      send(12'h006);
      check("rx_signaling_bits", {7'h00, rx_signaling_bits}, 8'h01);
      send(12'h002);
      check("rx_signaling_bits", {7'h00, rx_signaling_bits}, 8'h00);
      send(12'h004);
      check("rx_signaling_bits", {7'h00, rx_signaling_bits}, 8'h00);
      // Reset in mid-run brings the registers back and forces resync.
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk_sync(1'b1);
      chk_irq(1'b0);
      check_reg(rxar_pkg::OFS_MASK, rxar_pkg::RST_MASK);
      check_reg(rxar_pkg::OFS_VIOL_COUNT, rxar_pkg::RST_VIOL_COUNT);
      check_reg(rxar_pkg::OFS_ERR_COUNT, 8'h00);
      wrap_up();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_fail++;
      wrap_up();
   end
endmodule
